// *** bench/main_memory_model.sv ***
// Behavioural main memory holding stack and program areas
`timescale 1ns/1ps
module main_memory_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] ackDelay,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [19:0] memAddr,
  input wire logic [50:0] memWdata,
  output logic [50:0] memRdata,
  output logic memAck
);
  logic [50:0] cells [0:511];
  logic [50:0] rdReg;
  logic [3:0] waitCnt;

  // Off the ack cycle the bus carries the inverse, so a late sample shows
  assign memRdata = memAck ? rdReg : ~rdReg;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      memAck <= 1'b0;
      rdReg <= 51'h0;
      waitCnt <= 4'h0;
    end else if (memAck) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
    end else if (memReq && waitCnt == ackDelay) begin
      memAck <= 1'b1;
      rdReg <= cells[memAddr[8:0]];
      if (memWe) cells[memAddr[8:0]] <= memWdata;
    end else if (memReq) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : main_memory_model

// *** bench/stack_addressing_unit_bench.sv ***
// Self-checking bench for the stack addressing unit
`timescale 1ns/1ps
module stack_addressing_unit_bench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic opValid = 1'b0;
  stack_unit_pkg::syllable_t opCode = stack_unit_pkg::OP_NAME_CALL;
  logic [24:0] opOperand = 25'h0;
  logic [3:0] ackDelay = 4'h0;
  logic opReady, memReq, memWe, memAck, tosValid, storeFault, faultSeen;
  logic [19:0] memAddr, stackPtr, markPtr;
  logic [50:0] memWdata, memRdata, tosWord;
  int errorCnt = 0;
  int checks = 0;

  always #10 mclk = ~mclk;

  stack_addressing_unit dut (.mclk(mclk), .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
    .opOperand(opOperand), .opReady(opReady), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .tosWord(tosWord), .tosValid(tosValid),
    .stackPtr(stackPtr), .markPtr(markPtr), .storeFault(storeFault));
  main_memory_model mem (.mclk(mclk), .arst_n(arst_n), .ackDelay(ackDelay), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));

  task automatic wrap_up;
    if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [50:0] exp, input logic [50:0] got);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [50:0] val(input logic [47:0] v);
    return {stack_unit_pkg::TAG_OPERAND, v};
  endfunction : val

  // Called from a settled point with opReady high; returns settled and idle
  task automatic op(input stack_unit_pkg::syllable_t c, input logic [24:0] o);
    int n;
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= c;
    opOperand <= o;
    @(posedge mclk);
    opValid <= 1'b0;
    faultSeen = 1'b0;
    for (n = 0; n < 300; n++) begin
      @(posedge mclk);
      #1;
      if (storeFault === 1'b1) faultSeen = 1'b1;
      if (opReady === 1'b1) break;
    end
    if (n == 300) begin
      errorCnt++;
      wrap_up();
    end
  endtask : op

  task automatic t_enter;
    op(stack_unit_pkg::OP_PROC_ENTER, {5'h01, 20'h0});
    check("mark tag", 51'h3, mem.cells[9'h101][50:48]);
    check("mark link", 51'h1, mem.cells[9'h101][19:0]);
    check("enter sp", 51'h101, stackPtr);
    check("enter fp", 51'h101, markPtr);
  endtask : t_enter

  task automatic t_statement;
    op(stack_unit_pkg::OP_NAME_CALL, {5'h01, 20'h00010});
    check("ref word", {stack_unit_pkg::TAG_INDIRECT_REF_WORD, 23'h0, 5'h01, 20'h00010}, tosWord);
    op(stack_unit_pkg::OP_FETCH_VALUE, {5'h01, 20'h00011});
    check("value y", val(48'h5), tosWord);
    op(stack_unit_pkg::OP_LITERAL_BYTE, 25'h00002);
    check("literal", val(48'h2), tosWord);
    op(stack_unit_pkg::OP_FETCH_VALUE, {5'h01, 20'h00012});
    op(stack_unit_pkg::OP_FETCH_VALUE, {5'h01, 20'h00013});
    check("value v", val(48'h4), tosWord);
    op(stack_unit_pkg::OP_ADD, 25'h0);
    check("sum", val(48'h7), tosWord);
    op(stack_unit_pkg::OP_MUL, 25'h0);
    check("product", val(48'hE), tosWord);
    op(stack_unit_pkg::OP_ADD, 25'h0);
    check("result", val(48'h13), tosWord);
    op(stack_unit_pkg::OP_STORE_DESTRUCTIVE, 25'h0);
    check("stored z", val(48'h13), mem.cells[9'h111]);
    check("empty sp", 51'h101, stackPtr);
    check("empty tos", 51'h0, tosValid);
  endtask : t_statement

  task automatic t_store_ref;
    op(stack_unit_pkg::OP_LITERAL_BYTE, 25'h0005A);
    op(stack_unit_pkg::OP_FETCH_VALUE, {5'h01, 20'h00014});
    op(stack_unit_pkg::OP_STORE_DESTRUCTIVE, 25'h0);
    check("desc store", val(48'h5A), mem.cells[9'h150]);
    op(stack_unit_pkg::OP_LITERAL_BYTE, 25'h00033);
    op(stack_unit_pkg::OP_NAME_CALL, {5'h01, 20'h00015});
    op(stack_unit_pkg::OP_STORE_DESTRUCTIVE, 25'h0);
    check("ref above", val(48'h33), mem.cells[9'h116]);
    check("store sp", 51'h101, stackPtr);
  endtask : t_store_ref

  task automatic t_fault;
    op(stack_unit_pkg::OP_LITERAL_BYTE, 25'h00001);
    op(stack_unit_pkg::OP_LITERAL_BYTE, 25'h00002);
    op(stack_unit_pkg::OP_STORE_DESTRUCTIVE, 25'h0);
    check("no ref", 51'h1, faultSeen);
    check("fault sp", 51'h101, stackPtr);
  endtask : t_fault

  task automatic t_nest_exit;
    op(stack_unit_pkg::OP_PROC_ENTER, {5'h02, 20'h0});
    check("nested link", 51'h1, mem.cells[9'h102][19:0]);
    check("nested fp", 51'h102, markPtr);
    op(stack_unit_pkg::OP_FETCH_VALUE, {5'h02, 20'h00008});
    check("local", val(48'h4D), tosWord);
    op(stack_unit_pkg::OP_PROC_EXIT, 25'h0);
    check("exit sp", 51'h101, stackPtr);
    check("exit fp", 51'h101, markPtr);
    op(stack_unit_pkg::OP_FETCH_VALUE, {5'h02, 20'h00008});
    check("restored base", val(48'h63), tosWord);
    op(stack_unit_pkg::OP_FETCH_VALUE, {5'h01, 20'h00011});
    check("outer level", val(48'h5), tosWord);
    op(stack_unit_pkg::OP_PROC_EXIT, 25'h0);
    check("last sp", 51'h100, stackPtr);
    check("last fp", 51'h100, markPtr);
  endtask : t_nest_exit

  initial begin
    // Level 1 base is the outer mark at 0x101; spills reach 0x105
    mem.cells[9'h112] = val(48'h5);
    mem.cells[9'h113] = val(48'h3);
    mem.cells[9'h114] = val(48'h4);
    mem.cells[9'h115] = {stack_unit_pkg::TAG_DATA_DESC, 28'h0, 20'h00150};
    mem.cells[9'h10A] = val(48'h4D);
    mem.cells[9'h008] = val(48'h63);
    repeat (6) @(posedge mclk);
    check("reset sp", 51'h100, stackPtr);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    t_enter();
    t_statement();
    @(posedge mclk);
    ackDelay <= 4'h3;
    t_store_ref();
    t_fault();
    t_nest_exit();
    wrap_up();
  end
endmodule : stack_addressing_unit_bench

// *** bench/stack_addressing_unit_props.sv ***
// Port-level assertions for the stack addressing unit
`timescale 1ns/1ps
module stack_addressing_unit_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic opValid,
  input wire stack_unit_pkg::syllable_t opCode,
  input wire logic [24:0] opOperand,
  input wire logic opReady,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [19:0] memAddr,
  input wire logic [50:0] memWdata,
  input wire logic [50:0] memRdata,
  input wire logic memAck,
  input wire logic [50:0] tosWord,
  input wire logic tosValid,
  input wire logic [19:0] stackPtr,
  input wire logic [19:0] markPtr,
  input wire logic storeFault
);
  stack_unit_pkg::syllable_t lastOp;
  logic [50:0] capTos;
  logic [50:0] capRd;
  logic [24:0] capOp;
  logic [19:0] capSp;
  logic [19:0] capFp;
  logic capTv;
  logic taken;

  assign taken = opValid && opReady;

  // State as it stood at the take edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lastOp <= stack_unit_pkg::OP_NAME_CALL;
      capTos <= 51'h0;
      capOp <= 25'h0;
      capSp <= 20'h0;
      capFp <= 20'h0;
      capTv <= 1'b0;
    end else if (taken) begin
      lastOp <= opCode;
      capTos <= tosWord;
      capOp <= opOperand;
      capSp <= stackPtr;
      capFp <= markPtr;
      capTv <= tosValid;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      capRd <= 51'h0;
    end else if (memReq && memAck && !memWe) begin
      capRd <= memRdata;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  name_call_push_a: assert property (taken && opCode == stack_unit_pkg::OP_NAME_CALL && !tosValid |=>
    ##1 opReady && tosValid && tosWord == {stack_unit_pkg::TAG_INDIRECT_REF_WORD, 23'h0, capOp})
    else $error("name call did not push a reference word");
  literal_push_a: assert property (taken && opCode == stack_unit_pkg::OP_LITERAL_BYTE && !tosValid |=>
    ##1 opReady && tosValid && tosWord == {stack_unit_pkg::TAG_OPERAND, 40'h0, capOp[7:0]})
    else $error("literal not pushed");
  fetch_value_a: assert property ($rose(opReady) && lastOp == stack_unit_pkg::OP_FETCH_VALUE |->
    tosValid && tosWord == capRd) else $error("fetched value not on top");
  add_sum_a: assert property ($rose(opReady) && lastOp == stack_unit_pkg::OP_ADD |->
    tosWord == {stack_unit_pkg::TAG_OPERAND, capTos[47:0] + capRd[47:0]}) else $error("wrong sum");
  mul_product_a: assert property ($rose(opReady) && lastOp == stack_unit_pkg::OP_MUL |->
    tosWord == {stack_unit_pkg::TAG_OPERAND, capTos[47:0] * capRd[47:0]}) else $error("wrong product");
  store_empties_a: assert property ($rose(opReady) && lastOp == stack_unit_pkg::OP_STORE_DESTRUCTIVE && capTv |->
    !tosValid && stackPtr == capSp - 20'h1) else $error("store left operands");
  enter_mark_a: assert property ($rose(opReady) && lastOp == stack_unit_pkg::OP_PROC_ENTER |->
    markPtr == stackPtr && stackPtr == capSp + 20'h1 + capTv) else $error("mark not inserted");
  mark_link_a: assert property (memReq && memWe && memWdata[50:48] == stack_unit_pkg::TAG_PROCEDURE_MARK_WORD |->
    memWdata[19:0] == memAddr - markPtr) else $error("bad mark link");
  exit_stack_a: assert property ($rose(opReady) && lastOp == stack_unit_pkg::OP_PROC_EXIT |->
    stackPtr == capFp - 20'h1) else $error("stack not cut back");
  exit_mark_a: assert property ($rose(opReady) && lastOp == stack_unit_pkg::OP_PROC_EXIT |->
    markPtr == capFp - capRd[19:0]) else $error("mark pointer not relinked");
  mem_hold_a: assert property (memReq && !memAck |=>
    memReq && $stable(memAddr) && $stable(memWe) && $stable(memWdata)) else $error("request changed early");
  fault_pulse_a: assert property (storeFault |-> lastOp == stack_unit_pkg::OP_STORE_DESTRUCTIVE ##1 !storeFault)
    else $error("fault pulse wrong");

  cover property (taken && opCode == stack_unit_pkg::OP_PROC_EXIT);
  cover property (storeFault);
  cover property ($rose(opReady) && lastOp == stack_unit_pkg::OP_MUL);
endmodule : stack_addressing_unit_props

bind stack_addressing_unit stack_addressing_unit_props props (.mclk(mclk), .arst_n(arst_n), .opValid(opValid),
  .opCode(opCode), .opOperand(opOperand), .opReady(opReady), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
  .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .tosWord(tosWord), .tosValid(tosValid),
  .stackPtr(stackPtr), .markPtr(markPtr), .storeFault(storeFault));

// *** design/level_base_file.sv ***
// Array of level-base registers with address-couple translation
`timescale 1ns/1ps
module level_base_file #(
  parameter int LEVEL_N = 32,
  parameter int LEVEL_W = 5,
  parameter int ADDR_W = 20
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [LEVEL_W-1:0] wrLevel,
  input wire logic [ADDR_W-1:0] wrBase,
  input wire logic [LEVEL_W-1:0] rdLevel,
  input wire logic [ADDR_W-1:0] rdIndex,
  output logic [ADDR_W-1:0] rdBase,
  output logic [ADDR_W-1:0] absAddr
);

  logic [ADDR_W-1:0] baseReg [LEVEL_N];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LEVEL_N; i++) begin
        baseReg[i] <= '0;
      end
    end else if (wrEn) begin
      baseReg[wrLevel] <= wrBase;
    end
  end

  assign rdBase = baseReg[rdLevel];
  assign absAddr = rdBase + rdIndex;

endmodule : level_base_file

// *** design/stack_addressing_unit.sv ***
// Stack syllable executor with procedure marks and level-base addressing
`timescale 1ns/1ps

module stack_addressing_unit (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic opValid,
  input wire stack_unit_pkg::syllable_t opCode,
  input wire logic [stack_unit_pkg::COUPLE_W-1:0] opOperand,
  output logic opReady,
  output logic memReq,
  output logic memWe,
  output logic [stack_unit_pkg::ADDR_W-1:0] memAddr,
  output logic [stack_unit_pkg::FULL_W-1:0] memWdata,
  input wire logic [stack_unit_pkg::FULL_W-1:0] memRdata,
  input wire logic memAck,
  output logic [stack_unit_pkg::FULL_W-1:0] tosWord,
  output logic tosValid,
  output logic [stack_unit_pkg::ADDR_W-1:0] stackPtr,
  output logic [stack_unit_pkg::ADDR_W-1:0] markPtr,
  output logic storeFault
);

  localparam int AW = stack_unit_pkg::ADDR_W;
  localparam int LW = stack_unit_pkg::LEVEL_W;
  localparam int WW = stack_unit_pkg::WORD_W;
  localparam int FW = stack_unit_pkg::FULL_W;
  localparam int TW = stack_unit_pkg::TAG_W;

  stack_unit_pkg::state_t stateReg, stateNext;
  stack_unit_pkg::syllable_t opReg;
  logic [stack_unit_pkg::COUPLE_W-1:0] operandReg;
  logic [FW-1:0] tosReg, secondReg;
  logic tosValidReg;
  logic [AW-1:0] spReg, fpReg;
  logic opReadyReg, memReqReg, memWeReg, faultReg;
  logic [AW-1:0] memAddrReg;
  logic [FW-1:0] memWdataReg;

  logic accept, memDone, memState, issue;
  logic [TW-1:0] tosTag, secondTag, refTag;
  logic tosIsRef, secondIsRef, storeOk;
  logic [FW-1:0] refWord, storedWord, markWord;
  logic [LW-1:0] xlLevel, opLevel;
  logic [AW-1:0] xlIndex, rdBase, absAddr, storeAddr, spPlus1;
  logic [AW-1:0] rdLink, rdSaved;
  logic [LW-1:0] rdLevel;
  logic baseWe;
  logic [LW-1:0] baseWrLevel;
  logic [AW-1:0] baseWrValue;
  logic [WW-1:0] aluResult;
  logic [2*WW-1:0] product;

  assign accept = opReadyReg && opValid;
  assign memDone = memReqReg && memAck;
  assign spPlus1 = spReg + stack_unit_pkg::ADDR_ONE;
  assign opLevel = operandReg[stack_unit_pkg::COUPLE_LVL_LSB +: LW];

  // Reference detection for the destructive store
  assign tosTag = tosReg[stack_unit_pkg::TAG_LSB +: TW];
  assign secondTag = secondReg[stack_unit_pkg::TAG_LSB +: TW];
  assign tosIsRef = (tosTag == stack_unit_pkg::TAG_INDIRECT_REF_WORD) ||
                    (tosTag == stack_unit_pkg::TAG_DATA_DESC);
  assign secondIsRef = (secondTag == stack_unit_pkg::TAG_INDIRECT_REF_WORD) ||
                       (secondTag == stack_unit_pkg::TAG_DATA_DESC);
  assign storeOk = tosIsRef || secondIsRef;
  assign refWord = tosIsRef ? tosReg : secondReg;
  assign storedWord = tosIsRef ? secondReg : tosReg;
  assign refTag = refWord[stack_unit_pkg::TAG_LSB +: TW];

  // Couple source: the store's reference, otherwise the syllable operand
  always_comb begin
    if (stateReg == stack_unit_pkg::ST_STORE_WR) begin
      xlLevel = refWord[stack_unit_pkg::COUPLE_LVL_LSB +: LW];
      xlIndex = refWord[stack_unit_pkg::COUPLE_IDX_LSB +: AW];
    end else begin
      xlLevel = opLevel;
      xlIndex = operandReg[stack_unit_pkg::COUPLE_IDX_LSB +: AW];
    end
  end

  // A descriptor carries an absolute address and bypasses level translation
  assign storeAddr = (refTag == stack_unit_pkg::TAG_DATA_DESC) ?
                     refWord[stack_unit_pkg::DESC_ADDR_LSB +: AW] : absAddr;

  // Mark word read back on exit
  assign rdLink = memRdata[stack_unit_pkg::MARK_LINK_LSB +: AW];
  assign rdSaved = memRdata[stack_unit_pkg::MARK_SAVED_LSB +: AW];
  assign rdLevel = memRdata[stack_unit_pkg::MARK_LEVEL_LSB +: LW];

  // Mark word keeps the displaced base so exit can restore the environment
  always_comb begin
    markWord = '0;
    markWord[stack_unit_pkg::TAG_LSB +: TW] = stack_unit_pkg::TAG_PROCEDURE_MARK_WORD;
    markWord[stack_unit_pkg::MARK_LINK_LSB +: AW] = spPlus1 - fpReg;
    markWord[stack_unit_pkg::MARK_SAVED_LSB +: AW] = rdBase;
    markWord[stack_unit_pkg::MARK_LEVEL_LSB +: LW] = opLevel;
  end

  // Popped word arrives on the read bus; second register is not loaded yet
  assign product = tosReg[WW-1:0] * memRdata[WW-1:0];

  always_comb begin
    if (opReg == stack_unit_pkg::OP_MUL) begin
      aluResult = product[WW-1:0];
    end else begin
      aluResult = tosReg[WW-1:0] + memRdata[WW-1:0];
    end
  end

  // Level-base updates on entry and exit
  always_comb begin
    baseWe = 1'b0;
    baseWrLevel = opLevel;
    baseWrValue = spPlus1;
    if (stateReg == stack_unit_pkg::ST_MARK_WR && memDone) begin
      baseWe = 1'b1;
    end else if (stateReg == stack_unit_pkg::ST_EXIT_RD && memDone) begin
      baseWe = 1'b1;
      baseWrLevel = rdLevel;
      baseWrValue = rdSaved;
    end
  end

  level_base_file #(
    .LEVEL_N(stack_unit_pkg::LEVEL_N),
    .LEVEL_W(LW),
    .ADDR_W(AW)
  ) levelBases (
    .mclk(mclk),
    .arst_n(arst_n),
    .wrEn(baseWe),
    .wrLevel(baseWrLevel),
    .wrBase(baseWrValue),
    .rdLevel(xlLevel),
    .rdIndex(xlIndex),
    .rdBase(rdBase),
    .absAddr(absAddr)
  );

  assign memState = (stateReg == stack_unit_pkg::ST_SPILL) || (stateReg == stack_unit_pkg::ST_FETCH) ||
                    (stateReg == stack_unit_pkg::ST_POP) || (stateReg == stack_unit_pkg::ST_MARK_WR) ||
                    (stateReg == stack_unit_pkg::ST_EXIT_RD) ||
                    (stateReg == stack_unit_pkg::ST_STORE_WR && storeOk);
  assign issue = memState && !memReqReg;

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      stack_unit_pkg::ST_IDLE: begin
        if (accept) begin
          case (opCode)
            stack_unit_pkg::OP_NAME_CALL,
            stack_unit_pkg::OP_LITERAL_BYTE: begin
              stateNext = tosValidReg ? stack_unit_pkg::ST_SPILL : stack_unit_pkg::ST_LOAD;
            end
            stack_unit_pkg::OP_FETCH_VALUE: begin
              stateNext = tosValidReg ? stack_unit_pkg::ST_SPILL : stack_unit_pkg::ST_FETCH;
            end
            stack_unit_pkg::OP_PROC_ENTER: begin
              stateNext = tosValidReg ? stack_unit_pkg::ST_SPILL : stack_unit_pkg::ST_MARK_WR;
            end
            stack_unit_pkg::OP_PROC_EXIT: begin
              stateNext = stack_unit_pkg::ST_EXIT_RD;
            end
            default: begin
              stateNext = stack_unit_pkg::ST_POP;
            end
          endcase
        end
      end
      stack_unit_pkg::ST_SPILL: begin
        if (memDone) begin
          if (opReg == stack_unit_pkg::OP_PROC_ENTER) begin
            stateNext = stack_unit_pkg::ST_MARK_WR;
          end else if (opReg == stack_unit_pkg::OP_FETCH_VALUE) begin
            stateNext = stack_unit_pkg::ST_FETCH;
          end else begin
            stateNext = stack_unit_pkg::ST_LOAD;
          end
        end
      end
      stack_unit_pkg::ST_LOAD: begin
        stateNext = stack_unit_pkg::ST_IDLE;
      end
      stack_unit_pkg::ST_POP: begin
        if (memDone) begin
          stateNext = (opReg == stack_unit_pkg::OP_STORE_DESTRUCTIVE) ?
                      stack_unit_pkg::ST_STORE_WR : stack_unit_pkg::ST_IDLE;
        end
      end
      stack_unit_pkg::ST_STORE_WR: begin
        if (!storeOk || memDone) begin
          stateNext = stack_unit_pkg::ST_IDLE;
        end
      end
      default: begin
        if (memDone) begin
          stateNext = stack_unit_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= stack_unit_pkg::ST_IDLE;
      opReadyReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      opReadyReg <= (stateNext == stack_unit_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opReg <= stack_unit_pkg::OP_NAME_CALL;
      operandReg <= '0;
    end else if (accept) begin
      opReg <= opCode;
      operandReg <= opOperand;
    end
  end

  // Memory port; request holds until acknowledged
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      memReqReg <= 1'b0;
      memWeReg <= 1'b0;
      memAddrReg <= '0;
      memWdataReg <= '0;
    end else if (issue) begin
      memReqReg <= 1'b1;
      memWeReg <= 1'b0;
      memWdataReg <= '0;
      case (stateReg)
        stack_unit_pkg::ST_SPILL: begin
          memWeReg <= 1'b1;
          memAddrReg <= spPlus1;
          memWdataReg <= tosReg;
        end
        stack_unit_pkg::ST_FETCH: begin
          memAddrReg <= absAddr;
        end
        stack_unit_pkg::ST_POP: begin
          memAddrReg <= spReg;
        end
        stack_unit_pkg::ST_STORE_WR: begin
          memWeReg <= 1'b1;
          memAddrReg <= storeAddr;
          memWdataReg <= storedWord;
        end
        stack_unit_pkg::ST_MARK_WR: begin
          memWeReg <= 1'b1;
          memAddrReg <= spPlus1;
          memWdataReg <= markWord;
        end
        default: begin
          memAddrReg <= fpReg;
        end
      endcase
    end else if (memDone) begin
      memReqReg <= 1'b0;
      memWeReg <= 1'b0;
    end
  end

  // Top-of-stack register; words below it live in memory
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tosReg <= '0;
      tosValidReg <= 1'b0;
      secondReg <= '0;
    end else begin
      case (stateReg)
        stack_unit_pkg::ST_LOAD: begin
          tosValidReg <= 1'b1;
          if (opReg == stack_unit_pkg::OP_NAME_CALL) begin
            tosReg <= {stack_unit_pkg::TAG_INDIRECT_REF_WORD,
                       {(WW - stack_unit_pkg::COUPLE_W){1'b0}}, operandReg};
          end else begin
            tosReg <= {stack_unit_pkg::TAG_OPERAND, {(WW - stack_unit_pkg::LIT_W){1'b0}},
                       operandReg[stack_unit_pkg::LIT_W-1:0]};
          end
        end
        stack_unit_pkg::ST_FETCH: begin
          if (memDone) begin
            tosReg <= memRdata;
            tosValidReg <= 1'b1;
          end
        end
        stack_unit_pkg::ST_POP: begin
          if (memDone) begin
            if (opReg == stack_unit_pkg::OP_STORE_DESTRUCTIVE) begin
              secondReg <= memRdata;
            end else if (opReg == stack_unit_pkg::OP_MUL) begin
              secondReg <= memRdata;
              tosReg <= {stack_unit_pkg::TAG_OPERAND, aluResult};
            end else begin
              tosReg <= {stack_unit_pkg::TAG_OPERAND, aluResult};
            end
          end
        end
        stack_unit_pkg::ST_STORE_WR: begin
          if (!storeOk || memDone) begin
            tosValidReg <= 1'b0;
          end
        end
        stack_unit_pkg::ST_SPILL,
        stack_unit_pkg::ST_EXIT_RD: begin
          if (memDone) begin
            tosValidReg <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Stack and mark pointers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      spReg <= stack_unit_pkg::SP_RESET;
      fpReg <= stack_unit_pkg::FP_RESET;
    end else if (memDone) begin
      case (stateReg)
        stack_unit_pkg::ST_SPILL: begin
          spReg <= spPlus1;
        end
        stack_unit_pkg::ST_POP: begin
          spReg <= spReg - stack_unit_pkg::ADDR_ONE;
        end
        stack_unit_pkg::ST_MARK_WR: begin
          spReg <= spPlus1;
          fpReg <= spPlus1;
        end
        stack_unit_pkg::ST_EXIT_RD: begin
          spReg <= fpReg - stack_unit_pkg::ADDR_ONE;
          fpReg <= fpReg - rdLink;
        end
        default: begin
        end
      endcase
    end
  end

  // Store with no reference among the two words drops both and flags it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      faultReg <= 1'b0;
    end else begin
      faultReg <= (stateReg == stack_unit_pkg::ST_STORE_WR) && !storeOk;
    end
  end

  assign opReady = opReadyReg;
  assign memReq = memReqReg;
  assign memWe = memWeReg;
  assign memAddr = memAddrReg;
  assign memWdata = memWdataReg;
  assign tosWord = tosReg;
  assign tosValid = tosValidReg;
  assign stackPtr = spReg;
  assign markPtr = fpReg;
  assign storeFault = faultReg;

endmodule : stack_addressing_unit

// *** inc/stack_unit_pkg.sv ***
// Shared constants and types for the stack addressing unit
package stack_unit_pkg;

  // Word layout: a tag above a data field
  localparam int WORD_W = 48;
  localparam int TAG_W = 3;
  localparam int TAG_LSB = WORD_W;
  localparam int FULL_W = TAG_W + WORD_W;

  // Addresses, levels and literals
  localparam int ADDR_W = 20;
  localparam int LEVEL_W = 5;
  localparam int LEVEL_N = 32;
  localparam int LIT_W = 8;

  // Address couple: index in the low bits, addressing level above it
  localparam int COUPLE_IDX_LSB = 0;
  localparam int COUPLE_LVL_LSB = ADDR_W;
  localparam int COUPLE_W = ADDR_W + LEVEL_W;

  // Data descriptor: absolute address in the low bits
  localparam int DESC_ADDR_LSB = 0;

  // Procedure mark word fields
  localparam int MARK_LINK_LSB = 0;
  localparam int MARK_SAVED_LSB = ADDR_W;
  localparam int MARK_LEVEL_LSB = 2 * ADDR_W;

  // Word tags
  localparam logic [TAG_W-1:0] TAG_OPERAND = 3'h0;
  localparam logic [TAG_W-1:0] TAG_INDIRECT_REF_WORD = 3'h1;
  localparam logic [TAG_W-1:0] TAG_PROCEDURE_MARK_WORD = 3'h3;
  localparam logic [TAG_W-1:0] TAG_DATA_DESC = 3'h5;

  // Pointer reset values and step
  localparam logic [ADDR_W-1:0] SP_RESET = 20'h00100;
  localparam logic [ADDR_W-1:0] FP_RESET = 20'h00100;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 20'h00001;

  typedef enum logic [2:0] {
    OP_NAME_CALL,
    OP_FETCH_VALUE,
    OP_LITERAL_BYTE,
    OP_ADD,
    OP_MUL,
    OP_STORE_DESTRUCTIVE,
    OP_PROC_ENTER,
    OP_PROC_EXIT
  } syllable_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SPILL,
    ST_LOAD,
    ST_FETCH,
    ST_POP,
    ST_STORE_WR,
    ST_MARK_WR,
    ST_EXIT_RD
  } state_t;

endpackage : stack_unit_pkg
